/* File: core/fsc_fault_status.v */
// Fault_digest_register and communication fault status registers
`timescale 1ns/1ps
`include "fsc_regs.vh"
// Behaviour
// - Summary ADC compare flag set when unmasked and any compare fault present.
// - Summary memory flag set when unmasked and any memory fault bit set.
// - Summary comm flag ORs all unmasked host, chain, heartbeat, tone, status sources.
// - Summary voltage flag from unmasked overvoltage or unmasked undervoltage faults.
// - Summary system flag set when unmasked and any system fault bit set.
// - Summary power flag set when unmasked and any power-rail fault bit set.
// - Host fault while transmitting response sets host transmit-response bit.
// - Host fault while receiving response sets host receive-response bit.
// - Host fault while receiving command sets host receive-command bit.
// - Host link clear signal sets link-clear detected bit.
// - Wake ping in active or sleep mode also sets link-clear bit.
// - Wake pin pulse while active also sets link-clear bit.
// - Unexpected stop on host link sets unexpected-stop bit.
// - Wake ping while already active also sets unexpected-stop bit.
// - Lower port byte fault while transmitting response sets its bit.
// - Lower port byte fault while receiving response sets its bit.
// - Upper port byte fault while receiving response sets its bit.
// - Upper port byte fault while receiving command sets its bit.
// - Upper port bit-level error causing byte faults sets its bit.
// - Summary register mirrors what drives the active-low fault output.
// - Writing 1 to a clear bit zeroes its faults; clear bit self-clears.
module fsc_fault_status (
  input  wire                   clk_sys,
  input  wire                   arst_n,
  input  wire [`FSC_ADDR_W-1:0] reg_addr,
  input  wire [7:0]             reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [7:0]             reg_rdata,
  output reg                    reg_rvalid,
  input  wire [1:0]             dev_mode,
  input  wire                   host_fault,
  input  wire                   host_tx_resp,
  input  wire                   host_rx_resp,
  input  wire                   host_rx_cmd,
  input  wire                   host_link_clear,
  input  wire                   wake_from_sleep_ping,
  input  wire                   wake_pin_pulse,
  input  wire                   host_stop_seen,
  input  wire                   lower_byte_fault,
  input  wire                   lower_tx_resp,
  input  wire                   lower_rx_resp,
  input  wire                   lower_rx_cmd,
  input  wire                   lower_bit_fault,
  input  wire                   upper_byte_fault,
  input  wire                   upper_tx_resp,
  input  wire                   upper_rx_resp,
  input  wire                   upper_rx_cmd,
  input  wire                   upper_bit_fault,
  input  wire [3:0]             comm3_set,
  input  wire                   prot_any,
  input  wire                   comp_any,
  input  wire [7:0]             nvm_fault,
  input  wire                   ov_any,
  input  wire                   uv_any,
  input  wire                   sys_any,
  input  wire                   pwr_any,
  output reg  [7:0]             fault_digest_register,
  output reg                    fault_out_n,
  output reg  [7:0]             fault_clear_ctrl_a,
  output reg  [7:0]             mask1_out
);
  reg  [7:0] mask1_r;
  reg  [7:0] mask2_r;
  reg  [7:0] clear2_r;
  reg  [7:0] clear1_nxt;
  reg  [7:0] clear2_nxt;
  reg  [7:0] rdata_nxt;
  wire [7:0] host_set;
  wire [7:0] chain_set;
  wire [7:0] comm3_set_b;
  wire [7:0] host_clr;
  wire [7:0] chain_clr;
  wire [7:0] comm3_clr;
  wire [7:0] host_link_fault_status;
  wire [7:0] chain_port_fault_status;
  wire [7:0] comm3_status;
  wire [7:0] summary_now;
  wire       is_active;
  wire       is_sleep;
  wire       wr_mask1;
  wire       wr_mask2;
  wire       wr_clear1;
  wire       wr_clear2;

  assign is_active = (dev_mode == `FSC_MODE_ACTIVE);
  assign is_sleep  = (dev_mode == `FSC_MODE_SLEEP);

  assign host_set[7:5] = 3'h0;
  assign host_set[`FSC_HL_TX_RESP] = host_fault & host_tx_resp;
  assign host_set[`FSC_HL_RX_RESP] = host_fault & host_rx_resp;
  assign host_set[`FSC_HL_RX_CMD]  = host_fault & host_rx_cmd;
  assign host_set[`FSC_HL_CLEAR]   = host_link_clear
                                   | (wake_from_sleep_ping & (is_active | is_sleep))
                                   | (wake_pin_pulse & is_active);
  assign host_set[`FSC_HL_STOP]    = host_stop_seen
                                   | (wake_from_sleep_ping & is_active);

  assign chain_set[`FSC_CP_LOW_TX]  = lower_byte_fault & lower_tx_resp;
  assign chain_set[`FSC_CP_LOW_RR]  = lower_byte_fault & lower_rx_resp;
  assign chain_set[`FSC_CP_LOW_RC]  = lower_byte_fault & lower_rx_cmd;
  assign chain_set[`FSC_CP_LOW_BIT] = lower_bit_fault;
  assign chain_set[`FSC_CP_UP_TX]   = upper_byte_fault & upper_tx_resp;
  assign chain_set[`FSC_CP_UP_RR]   = upper_byte_fault & upper_rx_resp;
  assign chain_set[`FSC_CP_UP_RC]   = upper_byte_fault & upper_rx_cmd;
  assign chain_set[`FSC_CP_UP_BIT]  = upper_bit_fault;

  assign comm3_set_b = {4'h0, comm3_set};

  // Clear pulses come from the self-clearing control bits
  assign host_clr  = {8{clear2_r[`FSC_C2_HOST]}};
  assign chain_clr = {8{clear2_r[`FSC_C2_CHAIN]}};
  assign comm3_clr = {4'h0, clear2_r[`FSC_C2_FCOMM], clear2_r[`FSC_C2_TONE],
                      clear2_r[`FSC_C2_HB], clear2_r[`FSC_C2_HB]};

  fsc_sticky_byte u_host (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .set_bits  (host_set),
    .clr_bits  (host_clr),
    .stat_bits (host_link_fault_status)
  );

  fsc_sticky_byte u_chain (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .set_bits  (chain_set),
    .clr_bits  (chain_clr),
    .stat_bits (chain_port_fault_status)
  );

  fsc_sticky_byte u_comm3 (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .set_bits  (comm3_set_b),
    .clr_bits  (comm3_clr),
    .stat_bits (comm3_status)
  );

  fsc_summary u_sum (
    .mask1      (mask1_r),
    .mask2      (mask2_r),
    .prot_any   (prot_any),
    .comp_any   (comp_any),
    .nvm_fault  (nvm_fault),
    .host_link  (host_link_fault_status),
    .chain_port (chain_port_fault_status),
    .comm3      (comm3_status),
    .ov_any     (ov_any),
    .uv_any     (uv_any),
    .sys_any    (sys_any),
    .pwr_any    (pwr_any),
    .summary    (summary_now)
  );

  assign wr_mask1  = reg_wr & (reg_addr == `FSC_ADDR_MASK1);
  assign wr_mask2  = reg_wr & (reg_addr == `FSC_ADDR_MASK2);
  assign wr_clear1 = reg_wr & (reg_addr == `FSC_ADDR_CLEAR1);
  assign wr_clear2 = reg_wr & (reg_addr == `FSC_ADDR_CLEAR2);

  // Clear controls: written ones last one cycle, then drop
  always @*
  begin
    clear1_nxt = `FSC_RESET_BYTE;
    if (wr_clear1)
      clear1_nxt = reg_wdata & `FSC_C1_WMASK;
  end

  always @*
  begin
    clear2_nxt = `FSC_RESET_BYTE;
    if (wr_clear2)
      clear2_nxt = reg_wdata & `FSC_C2_WMASK;
  end

  always @*
  begin
    rdata_nxt = `FSC_RESET_BYTE;
    case (reg_addr)
      `FSC_ADDR_SUMMARY:    rdata_nxt = summary_now;
      `FSC_ADDR_HOST_LINK:  rdata_nxt = host_link_fault_status;
      `FSC_ADDR_CHAIN_PORT: rdata_nxt = chain_port_fault_status;
      `FSC_ADDR_COMM3:      rdata_nxt = comm3_status;
      `FSC_ADDR_MASK1:      rdata_nxt = mask1_r;
      `FSC_ADDR_MASK2:      rdata_nxt = mask2_r & `FSC_M2_RMASK;
      `FSC_ADDR_CLEAR1:     rdata_nxt = fault_clear_ctrl_a;
      `FSC_ADDR_CLEAR2:     rdata_nxt = clear2_r;
      default:              rdata_nxt = `FSC_RESET_BYTE;
    endcase
  end

  // Status registers are read-only; writes to them fall through
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mask1_r <= `FSC_RESET_BYTE;
    end
    else if (wr_mask1)
    begin
      mask1_r <= reg_wdata;
    end
  end

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mask2_r <= `FSC_RESET_BYTE;
    end
    else if (wr_mask2)
    begin
      mask2_r <= reg_wdata;
    end
  end

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mask1_out <= `FSC_RESET_BYTE;
    end
    else
    begin
      mask1_out <= mask1_r;
    end
  end

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      clear2_r <= `FSC_RESET_BYTE;
    end
    else
    begin
      clear2_r <= clear2_nxt;
    end
  end

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fault_clear_ctrl_a <= `FSC_RESET_BYTE;
    end
    else
    begin
      fault_clear_ctrl_a <= clear1_nxt;
    end
  end

  // Read data reloads every cycle from the current address
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata <= `FSC_RESET_BYTE;
    end
    else
    begin
      reg_rdata <= rdata_nxt;
    end
  end

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
    end
  end

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fault_digest_register <= `FSC_RESET_BYTE;
    end
    else
    begin
      fault_digest_register <= summary_now;
    end
  end

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fault_out_n <= 1'b1;
    end
    else
    begin
      fault_out_n <= ~(|summary_now);
    end
  end
endmodule // fsc_fault_status

/* File: core/fsc_regs.vh */
// Register offsets, field positions and reset values for the fault_digest_register block
`ifndef FSC_REGS_VH
`define FSC_REGS_VH
`define FSC_ADDR_W            16
`define FSC_ADDR_SUMMARY      16'h052D
`define FSC_ADDR_HOST_LINK    16'h0530
`define FSC_ADDR_CHAIN_PORT   16'h0531
`define FSC_ADDR_COMM3        16'h0532
`define FSC_ADDR_MASK1        16'h0016
`define FSC_ADDR_MASK2        16'h0017
`define FSC_ADDR_CLEAR1       16'h0331
`define FSC_ADDR_CLEAR2       16'h0332
`define FSC_RESET_BYTE        8'h00
// Summary bit positions
`define FSC_SUM_PROT          7
`define FSC_SUM_COMP          6
`define FSC_SUM_NVM           5
`define FSC_SUM_COMM          4
`define FSC_SUM_OVUV          2
`define FSC_SUM_SYS           1
`define FSC_SUM_PWR           0
// Host link fault bits
`define FSC_HL_TX_RESP        4
`define FSC_HL_RX_RESP        3
`define FSC_HL_RX_CMD         2
`define FSC_HL_CLEAR          1
`define FSC_HL_STOP           0
// Mask 1 bits
`define FSC_M1_PROT           7
`define FSC_M1_UV             4
`define FSC_M1_OV             3
`define FSC_M1_COMP           2
`define FSC_M1_SYS            1
`define FSC_M1_PWR            0
// Mask 2 bits
`define FSC_M2_NVM_CRC        6
`define FSC_M2_NVM_DATA       5
`define FSC_M2_FCOMM          4
`define FSC_M2_TONE           3
`define FSC_M2_HB             2
`define FSC_M2_CHAIN          1
`define FSC_M2_HOST           0
// Clear 2 bits
`define FSC_C2_FCOMM          4
`define FSC_C2_TONE           3
`define FSC_C2_HB             2
`define FSC_C2_CHAIN          1
`define FSC_C2_HOST           0
// Comm3 bits
`define FSC_C3_FCOMM          3
`define FSC_C3_TONE           2
`define FSC_C3_HB_FAIL        1
`define FSC_C3_HB_FAST        0
// Chain port fault bits
`define FSC_CP_LOW_TX         7
`define FSC_CP_LOW_RR         6
`define FSC_CP_LOW_RC         5
`define FSC_CP_LOW_BIT        4
`define FSC_CP_UP_TX          3
`define FSC_CP_UP_RR          2
`define FSC_CP_UP_RC          1
`define FSC_CP_UP_BIT         0
// Writable bits of the clear registers, readable bits of mask 2
`define FSC_C1_WMASK          8'h9F
`define FSC_C2_WMASK          8'h7F
`define FSC_M2_RMASK          8'h7F
// Mode codes
`define FSC_MODE_ACTIVE       2'h1
`define FSC_MODE_SLEEP        2'h2
`endif

/* File: core/fsc_sticky_byte.v */
// Eight sticky fault bits with set-over-clear and per-bit clear
`timescale 1ns/1ps
module fsc_sticky_byte (
  input  wire       clk_sys,
  input  wire       arst_n,
  input  wire [7:0] set_bits,
  input  wire [7:0] clr_bits,
  output wire [7:0] stat_bits
);
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_bit
      reg bit_r;
      always @(posedge clk_sys or negedge arst_n)
      begin
        if (!arst_n)
          bit_r <= 1'b0;
        else if (set_bits[i])
          bit_r <= 1'b1;
        else if (clr_bits[i])
          bit_r <= 1'b0;
      end
      assign stat_bits[i] = bit_r;
    end
  endgenerate
endmodule // fsc_sticky_byte

/* File: core/fsc_summary.v */
// Combinational folding of masked fault sources into summary bits
`timescale 1ns/1ps
`include "fsc_regs.vh"
module fsc_summary (
  input  wire [7:0] mask1,
  input  wire [7:0] mask2,
  input  wire       prot_any,
  input  wire       comp_any,
  input  wire [7:0] nvm_fault,
  input  wire [7:0] host_link,
  input  wire [7:0] chain_port,
  input  wire [7:0] comm3,
  input  wire       ov_any,
  input  wire       uv_any,
  input  wire       sys_any,
  input  wire       pwr_any,
  output wire [7:0] summary
);
  wire nvm_crc;
  wire nvm_data;
  wire comm;
  // CRC bits are 4:3, remaining data bits masked separately
  assign nvm_crc  = ~mask2[`FSC_M2_NVM_CRC] & (|nvm_fault[4:3]);
  assign nvm_data = ~mask2[`FSC_M2_NVM_DATA] & ((|nvm_fault[7:5]) | (|nvm_fault[2:0]));
  assign comm = (~mask2[`FSC_M2_HOST] & (|host_link))
              | (~mask2[`FSC_M2_CHAIN] & (|chain_port))
              | (~mask2[`FSC_M2_HB] & (comm3[`FSC_C3_HB_FAST] | comm3[`FSC_C3_HB_FAIL]))
              | (~mask2[`FSC_M2_TONE] & comm3[`FSC_C3_TONE])
              | (~mask2[`FSC_M2_FCOMM] & comm3[`FSC_C3_FCOMM]);
  assign summary[`FSC_SUM_PROT] = ~mask1[`FSC_M1_PROT] & prot_any;
  assign summary[`FSC_SUM_COMP] = ~mask1[`FSC_M1_COMP] & comp_any;
  assign summary[`FSC_SUM_NVM]  = nvm_crc | nvm_data;
  assign summary[`FSC_SUM_COMM] = comm;
  assign summary[3]             = 1'b0;
  assign summary[`FSC_SUM_OVUV] = (~mask1[`FSC_M1_OV] & ov_any) | (~mask1[`FSC_M1_UV] & uv_any);
  assign summary[`FSC_SUM_SYS]  = ~mask1[`FSC_M1_SYS] & sys_any;
  assign summary[`FSC_SUM_PWR]  = ~mask1[`FSC_M1_PWR] & pwr_any;
endmodule // fsc_summary

/* File: verif/fsc_fault_status_properties.sv */
// Port-level assertions for the fault status block
`timescale 1ns/1ps
module fsc_fault_status_properties (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        reg_wr,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        host_fault,
  input wire logic        host_tx_resp,
  input wire logic        host_link_clear,
  input wire logic        host_stop_seen,
  input wire logic        upper_bit_fault,
  input wire logic        upper_byte_fault,
  input wire logic        upper_rx_resp,
  input wire logic        comp_any,
  input wire logic        ov_any,
  input wire logic        uv_any,
  input wire logic        sys_any,
  input wire logic        pwr_any,
  input wire logic [7:0]  nvm_fault,
  input wire logic [7:0]  fault_digest_register,
  input wire logic        fault_out_n,
  input wire logic [7:0]  fault_clear_ctrl_a,
  input wire logic [7:0]  mask1_out
);
  logic [7:0] m1_r;
  logic [7:0] m2_r;
  // Shadows of both mask registers
  always @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      m1_r <= 8'h00;
      m2_r <= 8'h00;
    end
    else if (reg_wr && reg_addr == 16'h0016)
      m1_r <= reg_wdata;
    else if (reg_wr && reg_addr == 16'h0017)
      m2_r <= reg_wdata;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_comm_up;
    ##2 fault_digest_register[4];
  endsequence
  sequence s_clr_pulse;
    ##1 (fault_clear_ctrl_a & 8'h9F) == ($past(reg_wdata) & 8'h9F) ##1 fault_clear_ctrl_a == 8'h00;
  endsequence
  property p_comp; 1 |=> fault_digest_register[6] == $past(comp_any & ~m1_r[2]); endproperty
  property p_nvm;
    1 |=> fault_digest_register[5] == $past(|nvm_fault[4:3] & ~m2_r[6] | |(nvm_fault & 8'hE7) & ~m2_r[5]);
  endproperty
  property p_ovuv; 1 |=> fault_digest_register[2] == $past(ov_any & ~m1_r[3] | uv_any & ~m1_r[4]); endproperty
  property p_sys; 1 |=> fault_digest_register[1] == $past(sys_any & ~m1_r[1]); endproperty
  property p_pwr; 1 |=> fault_digest_register[0] == $past(pwr_any & ~m1_r[0]); endproperty
  property p_mirror; fault_out_n == ~|fault_digest_register; endproperty
  property p_mask_copy; 1 |=> mask1_out == $past(m1_r); endproperty
  property p_clear; reg_wr && reg_addr == 16'h0331 |-> s_clr_pulse; endproperty
  property p_host;
    (host_fault && host_tx_resp || host_link_clear || host_stop_seen) && !m2_r[0] |-> s_comm_up;
  endproperty
  property p_chain; (upper_bit_fault || upper_byte_fault && upper_rx_resp) && !m2_r[1] |-> s_comm_up; endproperty
  a_comp: assert property (p_comp) else $error("compare flag wrong");
  a_nvm: assert property (p_nvm) else $error("memory flag wrong");
  a_ovuv: assert property (p_ovuv) else $error("voltage flag wrong");
  a_sys: assert property (p_sys) else $error("system flag wrong");
  a_pwr: assert property (p_pwr) else $error("power flag wrong");
  a_mirror: assert property (p_mirror) else $error("fault pin disagrees with summary");
  a_mask_copy: assert property (p_mask_copy) else $error("mask copy output wrong");
  a_clear: assert property (p_clear) else $error("clear pulse wrong");
  a_host: assert property (p_host) else $error("host fault not summarised");
  a_chain: assert property (p_chain) else $error("chain fault not summarised");
endmodule // fsc_fault_status_properties

bind fsc_fault_status fsc_fault_status_properties u_fsc_fault_status_properties (.*);

/* File: verif/fsc_link_model.sv */
// Host link and chain neighbour event source
`timescale 1ns/1ps
module fsc_link_model (
  input  wire logic       clk_sys,
  output wire logic       host_fault,
  output wire logic       host_tx_resp,
  output wire logic       host_rx_resp,
  output wire logic       host_rx_cmd,
  output wire logic       host_link_clear,
  output wire logic       wake_from_sleep_ping,
  output wire logic       wake_pin_pulse,
  output wire logic       host_stop_seen,
  output wire logic       lower_byte_fault,
  output wire logic       lower_tx_resp,
  output wire logic       lower_rx_resp,
  output wire logic       lower_rx_cmd,
  output wire logic       lower_bit_fault,
  output wire logic       upper_byte_fault,
  output wire logic       upper_tx_resp,
  output wire logic       upper_rx_resp,
  output wire logic       upper_rx_cmd,
  output wire logic       upper_bit_fault,
  output wire logic [3:0] comm3_set
);
  logic [12:0] ev_r = 13'h0000;
  logic [8:0]  ph_r = 9'h000;
  assign {host_fault, host_link_clear, wake_from_sleep_ping, wake_pin_pulse, host_stop_seen, lower_byte_fault,
          lower_bit_fault, upper_byte_fault, upper_bit_fault, comm3_set} = ev_r;
  assign {host_tx_resp, host_rx_resp, host_rx_cmd, lower_tx_resp, lower_rx_resp, lower_rx_cmd,
          upper_tx_resp, upper_rx_resp, upper_rx_cmd} = ph_r;
  // One-cycle event with its frame phase levels
  task send(input logic [12:0] e, input logic [8:0] p);
    @(negedge clk_sys);
    ev_r = e;
    ph_r = p;
    @(negedge clk_sys);
    ev_r = 13'h0000;
    ph_r = 9'h000;
  endtask
endmodule // fsc_link_model

/* File: verif/tb.sv */
// Self-checking testbench for the fault status block
`timescale 1ns/1ps
module tb;
  logic        clk_sys = 0, arst_n = 0, reg_wr = 0, reg_rd = 0;
  logic        prot_any = 0, comp_any = 0, ov_any = 0, uv_any = 0, sys_any = 0, pwr_any = 0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00, nvm_fault = 8'h00, m1, m2;
  logic [1:0]  dev_mode = 2'h1;
  logic [31:0] rnd = 32'hE014;
  wire         reg_rvalid, fault_out_n, host_fault, host_tx_resp, host_rx_resp, host_rx_cmd, host_link_clear;
  wire         wake_from_sleep_ping, wake_pin_pulse, host_stop_seen, lower_byte_fault, lower_tx_resp;
  wire         lower_rx_resp, lower_rx_cmd, lower_bit_fault, upper_byte_fault, upper_tx_resp;
  wire         upper_rx_resp, upper_rx_cmd, upper_bit_fault;
  wire [3:0]   comm3_set;
  wire [7:0]   reg_rdata, fault_digest_register, fault_clear_ctrl_a, mask1_out;
  logic [7:0]  expq[$];
  int          errors = 0, checks_done = 0, cyc = 0;

  fsc_fault_status u_fsc_fault_status (.*);
  fsc_link_model u_fsc_link_model (.*);

  always #4 clk_sys = ~clk_sys;

  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task wrap_up;
    if (errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task reg_write(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge clk_sys);
    reg_wr = 0;
  endtask

  task reg_read(input logic [15:0] a, input logic [7:0] x);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1;
    expq.push_back(x);
    @(negedge clk_sys);
    reg_rd = 0;
  endtask

  // Event in a given mode, read back, then clear all comm faults
  task ev_chk(input logic [1:0] m, input logic [12:0] e, input logic [8:0] p, input logic [7:0] a, x);
    @(negedge clk_sys);
    dev_mode = m;
    u_fsc_link_model.send(e, p);
    reg_read({8'h05, a}, x);
    reg_write(16'h0332, 8'h1F);
  endtask

  always @(posedge clk_sys)
    if (reg_rvalid === 1'b1)
    begin
      checks_done++;
      if (reg_rdata !== expq[0])
      begin
        errors++;
        $display("MISMATCH reg_rdata exp %h got %h", expq[0], reg_rdata);
      end
      void'(expq.pop_front());
    end

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      errors++;
      wrap_up;
    end
  end

  initial
  begin
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys) arst_n = 1;
    reg_write(16'h0530, 8'hFF);
    reg_write(16'h052D, 8'hFF);
    reg_read(16'h0530, 8'h00);
    reg_read(16'h052D, 8'h00);
    reg_read(16'h0600, 8'h00);
    ev_chk(2'h1, 13'h1000, 9'h100, 8'h30, 8'h10);
    ev_chk(2'h1, 13'h1000, 9'h080, 8'h30, 8'h08);
    ev_chk(2'h1, 13'h1000, 9'h040, 8'h30, 8'h04);
    ev_chk(2'h1, 13'h0800, 9'h000, 8'h30, 8'h02);
    ev_chk(2'h2, 13'h0400, 9'h000, 8'h30, 8'h02);
    ev_chk(2'h1, 13'h0400, 9'h000, 8'h30, 8'h03);
    ev_chk(2'h0, 13'h0400, 9'h000, 8'h30, 8'h00);
    ev_chk(2'h1, 13'h0200, 9'h000, 8'h30, 8'h02);
    ev_chk(2'h2, 13'h0200, 9'h000, 8'h30, 8'h00);
    ev_chk(2'h1, 13'h0100, 9'h000, 8'h30, 8'h01);
    ev_chk(2'h1, 13'h0080, 9'h020, 8'h31, 8'h80);
    ev_chk(2'h1, 13'h0080, 9'h010, 8'h31, 8'h40);
    ev_chk(2'h1, 13'h0020, 9'h002, 8'h31, 8'h04);
    ev_chk(2'h1, 13'h0020, 9'h001, 8'h31, 8'h02);
    ev_chk(2'h1, 13'h0010, 9'h000, 8'h31, 8'h01);
    ev_chk(2'h1, 13'h0080, 9'h008, 8'h31, 8'h20);
    ev_chk(2'h1, 13'h0040, 9'h000, 8'h31, 8'h10);
    ev_chk(2'h1, 13'h0020, 9'h004, 8'h31, 8'h08);
    ev_chk(2'h1, 13'h000C, 9'h000, 8'h32, 8'h0C);
    ev_chk(2'h1, 13'h0003, 9'h000, 8'h32, 8'h03);
    ev_chk(2'h1, 13'h0008, 9'h000, 8'h2D, 8'h10);
    ev_chk(2'h1, 13'h0004, 9'h000, 8'h2D, 8'h10);
    ev_chk(2'h1, 13'h0010, 9'h000, 8'h2D, 8'h10);
    reg_write(16'h0017, 8'h01);
    ev_chk(2'h1, 13'h1000, 9'h100, 8'h2D, 8'h00);
    reg_read(16'h0530, 8'h00);
    reg_read(16'h0332, 8'h00);
    repeat (12)
    begin
      rnd = lfsr(lfsr(rnd));
      m1 = rnd[7:0] & 8'h9F;
      m2 = rnd[15:8] & 8'h60;
      reg_write(16'h0016, m1);
      reg_write(16'h0017, m2);
      reg_write(16'h0331, rnd[23:16] & 8'h9F);
      rnd = lfsr(lfsr(rnd));
      @(negedge clk_sys);
      {prot_any, comp_any, ov_any, uv_any, sys_any, pwr_any} = rnd[5:0];
      nvm_fault = rnd[15:8];
      reg_read(16'h0016, m1);
      reg_read(16'h052D, {prot_any & ~m1[7], comp_any & ~m1[2], |nvm_fault[4:3] & ~m2[6] |
               |(nvm_fault & 8'hE7) & ~m2[5], 2'b00, ov_any & ~m1[3] | uv_any & ~m1[4],
               sys_any & ~m1[1], pwr_any & ~m1[0]});
    end
    repeat (4) @(posedge clk_sys);
    wrap_up;
  end
endmodule // tb
